// File: pcr_pkg.sv
// package for the pll control register block
package pcr_pkg;
    // ==================================================
    // register map
    localparam logic [9:0] PCR_OFF_CONTROL = 10'h100;
    localparam int PCR_ADDR_W = 10;
    // ==================================================
    // field positions
    localparam int PCR_BIT_REF_SEL = 8;
    localparam int PCR_BIT_RSVD_HI = 7;
    localparam int PCR_BIT_RSVD_LO = 6;
    localparam int PCR_BIT_EN_SRC = 5;
    localparam int PCR_BIT_DISABLE = 4;
    localparam int PCR_BIT_RESET_N = 3;
    localparam int PCR_BIT_PWR_DN = 1;
    localparam int PCR_BIT_MODE_EN = 0;
    // ==================================================
    // reset values
    localparam logic PCR_RST_REF_SEL = 1'h0;
    localparam logic PCR_RST_EN_SRC = 1'h1;
    localparam logic PCR_RST_DISABLE = 1'h1;
    localparam logic PCR_RST_RESET_N = 1'h0;
    localparam logic PCR_RST_PWR_DN = 1'h1;
    localparam logic PCR_RST_MODE_EN = 1'h0;
    localparam logic [1:0] PCR_RSVD_7_6 = 2'h3;
    localparam logic [31:0] PCR_UNMAPPED_DATA = 32'h0000_0000;

    // ==================================================
    // control fields carried together
    typedef struct packed {
        logic reference_select;
        logic enable_source_gate;
        logic pll_disable;
        logic pll_reset_n;
        logic pll_power_down;
        logic pll_mode_enable;
    } pcr_ctrl_t;

    localparam pcr_ctrl_t PCR_CTRL_RESET = '{
        reference_select: PCR_RST_REF_SEL,
        enable_source_gate: PCR_RST_EN_SRC,
        pll_disable: PCR_RST_DISABLE,
        pll_reset_n: PCR_RST_RESET_N,
        pll_power_down: PCR_RST_PWR_DN,
        pll_mode_enable: PCR_RST_MODE_EN
    };

    // bus state machine, one-hot
    typedef enum logic [1:0] {
        PCR_IDLE = 2'b01,
        PCR_DONE = 2'b10
    } pcr_state_t;

    // pack control fields into the register image
    function automatic logic [31:0] pcr_image(input pcr_ctrl_t c);
        logic [31:0] v;
        v = 32'h0000_0000;
        v[PCR_BIT_REF_SEL] = c.reference_select;
        v[PCR_BIT_RSVD_HI:PCR_BIT_RSVD_LO] = PCR_RSVD_7_6;
        v[PCR_BIT_EN_SRC] = c.enable_source_gate;
        v[PCR_BIT_DISABLE] = c.pll_disable;
        v[PCR_BIT_RESET_N] = c.pll_reset_n;
        v[PCR_BIT_PWR_DN] = c.pll_power_down;
        v[PCR_BIT_MODE_EN] = c.pll_mode_enable;
        return v;
    endfunction
endpackage

// File: pcr_pll_control.sv
// pll control register with avalon-mm slave and pll control outputs
`timescale 1ns/1ps
// ==================================================
// Operation
// - select 0 uses internal oscillator for crystal
// - select 1: square wave, bias resistor off
// - mode enable ignored until gate cleared
// - disable bit 1 asserts pll disable
// - disable bit 0 releases pll disable
// - reset bit 0 holds pll in reset
// - reset bit 1 releases pll reset
// - power down bit 1 powers pll down
// - mode bit 0 bypass, 1 pll mode
// - divider source follows mode: pll or reference
module pcr_pll_control
    import pcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic osc_bias_enable,
    output logic pll_disable,
    output logic pll_reset_n,
    output logic pll_power_down,
    output logic pll_bypass,
    output logic div_src_pll
);
    // ==================================================
    // decode
    pcr_ctrl_t ctrl;
    pcr_ctrl_t next_ctrl;
    pcr_state_t state;
    pcr_state_t next_state;
    wire logic hit = (avs_address == PCR_OFF_CONTROL);
    wire logic req = avs_read | avs_write;
    wire logic idle = (state == PCR_IDLE);
    wire logic answer = idle & req;
    wire logic rd_take = idle & avs_read;
    wire logic wr_lo = idle & avs_write & hit & avs_byteenable[0];
    wire logic wr_b1 = idle & avs_write & hit & avs_byteenable[1];
    wire logic [31:0] rd_value = hit ? pcr_image(ctrl) : PCR_UNMAPPED_DATA;
    // gate cleared lets the mode bit through; a set gate forces bypass
    wire logic mode_active = ctrl.pll_mode_enable & ~ctrl.enable_source_gate;

    // ==================================================
    // write merge, reserved bits never stored
    always_comb
    begin
        next_ctrl = ctrl;
        if (wr_lo)
        begin
            next_ctrl.enable_source_gate = avs_writedata[PCR_BIT_EN_SRC];
            next_ctrl.pll_disable = avs_writedata[PCR_BIT_DISABLE];
            next_ctrl.pll_reset_n = avs_writedata[PCR_BIT_RESET_N];
            next_ctrl.pll_power_down = avs_writedata[PCR_BIT_PWR_DN];
            next_ctrl.pll_mode_enable = avs_writedata[PCR_BIT_MODE_EN];
        end
        if (wr_b1)
        begin
            next_ctrl.reference_select = avs_writedata[PCR_BIT_REF_SEL];
        end
    end

    // one wait cycle, then the answer; keeps readdata registered
    always_comb
    begin
        case (state)
            PCR_IDLE: next_state = req ? PCR_DONE : PCR_IDLE;
            PCR_DONE: next_state = PCR_IDLE;
            default: next_state = PCR_IDLE;
        endcase
    end

    // ==================================================
    // registers
    // reset leaves the pll disabled, in reset and powered down
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ctrl <= PCR_CTRL_RESET;
        end
        else
        begin
            ctrl <= next_ctrl;
        end
    end

    // one-hot bus sequencer
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= PCR_IDLE;
        end
        else
        begin
            state <= next_state;
        end
    end

    // ==================================================
    // bus answer
    // stall during reset so no request is taken half-way
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            avs_waitrequest <= 1'h1;
        end
        else
        begin
            avs_waitrequest <= ~answer;
        end
    end

    // readdata only moves on a read, so it stands until the next one
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            avs_readdata <= 32'h0000_0000;
        end
        else if (rd_take)
        begin
            avs_readdata <= rd_value;
        end
    end

    // ==================================================
    // pll control outputs, registered one cycle after the field
    // outputs lag the register by a clock; software never sees the gap
    wire logic next_osc_bias_enable = ~ctrl.reference_select;
    wire logic next_pll_bypass = ~mode_active;
    wire logic next_div_src_pll = mode_active;

    // crystal needs the bias resistor; a square wave does not
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            osc_bias_enable <= ~PCR_RST_REF_SEL;
        end
        else
        begin
            osc_bias_enable <= next_osc_bias_enable;
        end
    end

    // disable stops the pll output toggling
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pll_disable <= PCR_RST_DISABLE;
        end
        else
        begin
            pll_disable <= ctrl.pll_disable;
        end
    end

    // active low, so reset holds the pll in reset
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pll_reset_n <= PCR_RST_RESET_N;
        end
        else
        begin
            pll_reset_n <= ctrl.pll_reset_n;
        end
    end

    // powering up is immediate; the settling wait is software's
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pll_power_down <= PCR_RST_PWR_DN;
        end
        else
        begin
            pll_power_down <= ctrl.pll_power_down;
        end
    end

    // bypass and divider source come from one term, so they never disagree
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pll_bypass <= ~(PCR_RST_MODE_EN & ~PCR_RST_EN_SRC);
        end
        else
        begin
            pll_bypass <= next_pll_bypass;
        end
    end

    // low selects the reference_clock_input pin
    always_ff @(posedge sys_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_src_pll <= PCR_RST_MODE_EN & ~PCR_RST_EN_SRC;
        end
        else
        begin
            div_src_pll <= next_div_src_pll;
        end
    end
endmodule // pcr_pll_control

// File: pcr_pll_control_asserts.sv
// assertion checker for the pll control register
`timescale 1ns/1ps
module pcr_pll_control_asserts
    import pcr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic osc_bias_enable,
    input wire logic pll_disable,
    input wire logic pll_reset_n,
    input wire logic pll_power_down,
    input wire logic pll_bypass,
    input wire logic div_src_pll
);
    // ====
    // write seen in cycle 0 only, lane 0 or lane 1
    wire logic hit = avs_write && avs_waitrequest && avs_address == PCR_OFF_CONTROL;
    wire logic wr0 = hit && avs_byteenable[0];
    wire logic wr1 = hit && avs_byteenable[1];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    chk_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("no answer after one wait");
    chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("answer longer than one cycle");
    chk_disable_bit: assert property (wr0 |=> ##1 pll_disable == $past(avs_writedata[4], 2))
        else $error("disable output wrong");
    chk_reset_bit: assert property (wr0 |=> ##1 pll_reset_n == $past(avs_writedata[3], 2))
        else $error("reset output wrong");
    chk_pwrdn_bit: assert property (wr0 |=> ##1 pll_power_down == $past(avs_writedata[1], 2))
        else $error("power down output wrong");
    chk_mode_gate: assert property (wr0 |=> ##1 div_src_pll ==
        ($past(avs_writedata[0], 2) && !$past(avs_writedata[5], 2))) else $error("mode wrong");
    chk_bypass_pair: assert property (pll_bypass != div_src_pll)
        else $error("bypass and source disagree");
    chk_bias_sel: assert property (wr1 |=> ##1 osc_bias_enable == !$past(avs_writedata[8], 2))
        else $error("bias output wrong");
    chk_rsvd_read: assert property ($fell(avs_waitrequest) && $past(avs_read) &&
        $past(avs_address) == PCR_OFF_CONTROL |-> avs_readdata[7:6] == 2'h3 &&
        avs_readdata[2] == 1'h0 && avs_readdata[31:9] == 23'h0) else $error("reserved bits wrong");
    cover property (wr0);
    cover property (div_src_pll);
    cover property (avs_read && !avs_waitrequest);
endmodule // pcr_pll_control_asserts

// File: pcr_pll_control_tb.sv
// self-checking testbench for the pll control register
`timescale 1ns/1ps
module pcr_pll_control_tb
    import pcr_pkg::*;
;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0] avs_byteenable = 4'h0;
    logic [31:0] avs_readdata, rd;
    logic avs_waitrequest, osc_bias_enable, pll_disable, pll_reset_n;
    logic pll_power_down, pll_bypass, div_src_pll;
    int num_errors = 0;
    int num_checks = 0;
    int cyc = 0;
    // settling time granted to the pll after it is powered up
    localparam int SETTLE_CYCLES = 4;
    wire logic [31:0] outs = {26'h0000000, osc_bias_enable, pll_disable, pll_reset_n,
        pll_power_down, pll_bypass, div_src_pll};
    pcr_pll_control DUT (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .avs_address(avs_address),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest),
        .osc_bias_enable(osc_bias_enable),
        .pll_disable(pll_disable),
        .pll_reset_n(pll_reset_n),
        .pll_power_down(pll_power_down),
        .pll_bypass(pll_bypass),
        .div_src_pll(div_src_pll)
    );
    initial forever #25 sys_clk = ~sys_clk;
    // ====
    // comparison and bus tasks
    task chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e)
        begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // hold the request until waitrequest is sampled low
    task bus(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge sys_clk);
        avs_read <= !w;
        avs_write <= w;
        avs_address <= a;
        avs_writedata <= d;
        avs_byteenable <= be;
        do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task wr_rd(input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, a, d, be);
        bus(1'b0, a, 32'h0, 4'hf);
    endtask
    // ====
    // scenarios
    task t_reset;
        bus(1'b0, PCR_OFF_CONTROL, 32'h0, 4'hf);
        chk("image", 32'h0000_00f2, rd);
        chk("outs", 32'h36, outs);
        $display("test reset done");
    endtask
    task t_fields;
        wr_rd(PCR_OFF_CONTROL, 32'hffff_ffff, 4'hf);
        chk("image", 32'h0000_01fb, rd);
        chk("outs", 32'h1e, outs);
        wr_rd(PCR_OFF_CONTROL, 32'h0000_0009, 4'h1);
        repeat (SETTLE_CYCLES) @(posedge sys_clk);
        chk("image", 32'h0000_01c9, rd);
        chk("outs", 32'h09, outs);
        wr_rd(PCR_OFF_CONTROL, 32'h0, 4'h2);
        chk("outs", 32'h29, outs);
        wr_rd(PCR_OFF_CONTROL, 32'h0000_0029, 4'h1);
        chk("outs", 32'h2a, outs);
        $display("test fields done");
    endtask
    task t_unmapped;
        wr_rd(10'h104, 32'hffff_ffff, 4'hf);
        chk("unmapped", PCR_UNMAPPED_DATA, rd);
        wr_rd(PCR_OFF_CONTROL, 32'hffff_ffff, 4'hc);
        chk("upper lanes", 32'h0000_00e9, rd);
        bus(1'b0, PCR_OFF_CONTROL, 32'h0, 4'hf);
        chk("image", 32'h0000_00e9, rd);
        $display("test unmapped done");
    endtask
    // async reset in mid-run must bring every field back
    task t_midreset;
        wr_rd(PCR_OFF_CONTROL, 32'h0000_0109, 4'h3);
        chk("image", 32'h0000_01c9, rd);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("outs", 32'h36, outs);
        sys_rst <= 1'b0;
        bus(1'b0, PCR_OFF_CONTROL, 32'h0, 4'hf);
        chk("image", 32'h0000_00f2, rd);
        $display("test mid reset done");
    endtask
    task stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // a hang is cut short well past the expected run
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            num_errors++;
            stop_test;
        end
    end
    initial
    begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        t_reset;
        t_fields;
        t_unmapped;
        t_midreset;
        stop_test;
    end
endmodule // pcr_pll_control_tb
bind pcr_pll_control pcr_pll_control_asserts u_chk (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .osc_bias_enable(osc_bias_enable),
    .pll_disable(pll_disable),
    .pll_reset_n(pll_reset_n),
    .pll_power_down(pll_power_down),
    .pll_bypass(pll_bypass),
    .div_src_pll(div_src_pll)
);
